// [hdl/pew_pkg.sv]
// constants, types and timing counts for the parallel eeprom host controller
// assumes a 20 MHz system clock
package pew_pkg;
    localparam int CLK_MHZ = 20;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int PAGE_BYTES = 32;
    localparam int BYTE_SEL_W = 5;
    localparam int MSB_BIT = 7;
    // pin timing in ns, cycles rounded up; read gets one cycle more
    localparam int T_STROBE_NS = 150;
    localparam int T_SETUP_NS = 70;
    localparam int T_READ_NS = 200;
    localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int READ_CYC = (T_READ_NS * CLK_MHZ + 999) / 1000 + 1;
    // page load window in us: least bound rounds down (must start within), max rounds up
    localparam int LOAD_MIN_US = 10;
    localparam int LOAD_MAX_US = 100;
    localparam int LOAD_MIN_CYC = LOAD_MIN_US * CLK_MHZ;
    localparam int LOAD_MAX_CYC = LOAD_MAX_US * CLK_MHZ;
    // write cycle and power-up inhibit in ms
    localparam int T_WRITE_MS = 10;
    localparam int T_INHIBIT_MS = 20;
    localparam int WRITE_CYC = T_WRITE_MS * 1000 * CLK_MHZ;
    localparam int INHIBIT_CYC = T_INHIBIT_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 24;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic write;
        logic last;
    } pew_req_t;

    typedef struct packed {
        logic cs_n;
        logic oe_n;
        logic we_n;
    } pew_ctl_t;

    typedef enum logic [3:0] {
        ST_INHIBIT = 4'h0,
        ST_IDLE = 4'h1,
        ST_RD_WAIT = 4'h2,
        ST_WR_SETUP = 4'h3,
        ST_WR_LOW = 4'h4,
        ST_WR_HIGH = 4'h5,
        ST_LOAD_GAP = 4'h6,
        ST_COMMIT = 4'h7,
        ST_POLL = 4'h8,
        ST_POLL_GAP = 4'h9
    } pew_state_t;
endpackage

// [hdl/pew_host.sv]
// host controller driving an 8k x 8 parallel eeprom through its pins
// assumes the eeprom pins are wired straight to the ports; one clock domain
// What this block does
// - write starts only with chip select and strobe low, output enable high.
// - address bits 4..0 choose the byte; any order allowed.
// - host starts each next load within 10 us of previous strobe rise.
// - after last load, strobe stays high 100 us before programming.
`timescale 1ns/10ps
module pew_host
    import pew_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // request side
    input wire pew_pkg::pew_req_t req_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    output logic [pew_pkg::DATA_W-1:0] rd_data_o,
    output logic rd_valid_o,
    output logic prog_done_o,
    output logic busy_o,
    // supply sense
    input wire logic power_good_i,
    // device pins
    output logic [pew_pkg::ADDR_W-1:0] mem_addr_o,
    output pew_pkg::pew_ctl_t mem_ctl_o,
    input wire logic [pew_pkg::DATA_W-1:0] mem_data_i,
    output logic [pew_pkg::DATA_W-1:0] mem_data_o,
    output logic mem_data_oe_o
);
    import pew_pkg::*;

    pew_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [DATA_W-1:0] din_s1, din_s2, din_s3;
    logic pg_s1, pg_s2, pg_s3, pg_ok;
    logic [ADDR_W-BYTE_SEL_W-1:0] page_hold;
    logic [ADDR_W-1:0] last_addr;
    logic last_msb;
    logic in_page;

    // data lines cross in through three flops; settled when stages 2 and 3 agree
    wire din_stable = (din_s2 == din_s3);
    wire [CNT_W-1:0] cnt_inc = cnt + 24'h000001;
    wire req_take = req_valid_i && req_ready_o;
    // same page as the held page
    wire same_page = req_i.addr[ADDR_W-1:BYTE_SEL_W] == page_hold;
    // next load only within window, and only same page
    wire load_ok = req_valid_i && req_i.write && in_page && same_page;
    // poll reads last byte; done when msb matches the msb of the last byte written
    wire poll_done = din_stable && (din_s3[MSB_BIT] == last_msb);

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            din_s1 <= 8'h00;
            din_s2 <= 8'h00;
            din_s3 <= 8'h00;
            pg_s1 <= 1'b0;
            pg_s2 <= 1'b0;
            pg_s3 <= 1'b0;
            pg_ok <= 1'b0;
        end else if (ce_i) begin
            din_s1 <= mem_data_i;
            din_s2 <= din_s1;
            din_s3 <= din_s2;
            pg_s1 <= power_good_i;
            pg_s2 <= pg_s1;
            pg_s3 <= pg_s2;
            if (pg_s2 == pg_s3) begin
                pg_ok <= pg_s3;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state <= ST_INHIBIT;
            cnt <= '0;
            page_hold <= '0;
            last_addr <= '0;
            last_msb <= 1'b0;
            in_page <= 1'b0;
            req_ready_o <= 1'b0;
            rd_data_o <= 8'h00;
            rd_valid_o <= 1'b0;
            prog_done_o <= 1'b0;
            busy_o <= 1'b1;
            mem_addr_o <= '0;
            mem_ctl_o <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
            mem_data_o <= 8'h00;
            mem_data_oe_o <= 1'b0;
        end else if (ce_i) begin
            rd_valid_o <= 1'b0;
            prog_done_o <= 1'b0;
            case (state)
                // wait out the power-up inhibit; and again on a supply drop seen in ST_IDLE
                ST_INHIBIT: begin
                    busy_o <= 1'b1;
                    mem_ctl_o <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
                    if (!pg_ok) begin
                        cnt <= '0;
                    end else if (cnt_inc >= CNT_W'(INHIBIT_CYC)) begin
                        state <= ST_IDLE;
                        busy_o <= 1'b0;
                        req_ready_o <= 1'b1;
                    end else begin
                        cnt <= cnt_inc;
                    end
                end
                ST_IDLE: begin
                    mem_ctl_o <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
                    mem_data_oe_o <= 1'b0;
                    cnt <= '0;
                    if (!pg_ok) begin
                        state <= ST_INHIBIT;
                        req_ready_o <= 1'b0;
                        busy_o <= 1'b1;
                    end else if (req_take) begin
                        req_ready_o <= 1'b0;
                        busy_o <= 1'b1;
                        mem_addr_o <= req_i.addr;
                        if (req_i.write) begin
                            // page held from the first strobe
                            page_hold <= req_i.addr[ADDR_W-1:BYTE_SEL_W];
                            last_addr <= req_i.addr;
                            last_msb <= req_i.data[MSB_BIT];
                            mem_data_o <= req_i.data;
                            mem_data_oe_o <= 1'b1;
                            in_page <= !req_i.last;
                            // output enable high before chip select falls
                            mem_ctl_o <= '{cs_n: 1'b0, oe_n: 1'b1, we_n: 1'b1};
                            state <= ST_WR_SETUP;
                        end else begin
                            mem_ctl_o <= '{cs_n: 1'b0, oe_n: 1'b0, we_n: 1'b1};
                            state <= ST_RD_WAIT;
                        end
                    end
                end
                ST_RD_WAIT: begin
                    // data lines count only once stages 2 and 3 agree
                    if (cnt_inc >= CNT_W'(READ_CYC) && din_stable) begin
                        rd_data_o <= din_s3;
                        rd_valid_o <= 1'b1;
                        mem_ctl_o <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
                        busy_o <= 1'b0;
                        req_ready_o <= 1'b1;
                        state <= ST_IDLE;
                    end else begin
                        cnt <= cnt_inc;
                    end
                end
                ST_WR_SETUP: begin
                    // strobe falls last, address already stable
                    mem_ctl_o.we_n <= 1'b0;
                    cnt <= '0;
                    state <= ST_WR_LOW;
                end
                ST_WR_LOW: begin
                    // pulse held well over 20 ns
                    if (cnt_inc >= CNT_W'(STROBE_CYC)) begin
                        // strobe rises first; data still driven
                        mem_ctl_o.we_n <= 1'b1;
                        cnt <= '0;
                        state <= ST_WR_HIGH;
                    end else begin
                        cnt <= cnt_inc;
                    end
                end
                ST_WR_HIGH: begin
                    mem_ctl_o.cs_n <= 1'b1;
                    mem_data_oe_o <= 1'b0;
                    cnt <= '0;
                    // more bytes go to the page buffer
                    if (in_page) begin
                        req_ready_o <= 1'b1;
                        state <= ST_LOAD_GAP;
                    end else begin
                        state <= ST_COMMIT;
                    end
                end
                ST_LOAD_GAP: begin
                    // further loads, any byte order within the page
                    if (load_ok && cnt_inc < CNT_W'(LOAD_MIN_CYC - SETUP_CYC)) begin
                        req_ready_o <= 1'b0;
                        mem_addr_o <= req_i.addr;
                        last_addr <= req_i.addr;
                        last_msb <= req_i.data[MSB_BIT];
                        mem_data_o <= req_i.data;
                        mem_data_oe_o <= 1'b1;
                        in_page <= !req_i.last;
                        mem_ctl_o <= '{cs_n: 1'b0, oe_n: 1'b1, we_n: 1'b1};
                        state <= ST_WR_SETUP;
                    end else if (cnt_inc >= CNT_W'(LOAD_MIN_CYC - SETUP_CYC)) begin
                        // window closed; the page is committed
                        req_ready_o <= 1'b0;
                        in_page <= 1'b0;
                        cnt <= '0;
                        state <= ST_COMMIT;
                    end else begin
                        cnt <= cnt_inc;
                    end
                end
                ST_COMMIT: begin
                    // strobe stays high the full window before polling
                    if (cnt_inc >= CNT_W'(LOAD_MAX_CYC)) begin
                        cnt <= '0;
                        mem_addr_o <= last_addr;
                        mem_ctl_o <= '{cs_n: 1'b0, oe_n: 1'b0, we_n: 1'b1};
                        state <= ST_POLL;
                    end else begin
                        cnt <= cnt_inc;
                    end
                end
                ST_POLL: begin
                    // poll msb, no writes until done or timeout
                    if (cnt[4:0] >= 5'(READ_CYC) && poll_done) begin
                        mem_ctl_o <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
                        prog_done_o <= 1'b1;
                        busy_o <= 1'b0;
                        req_ready_o <= 1'b1;
                        state <= ST_IDLE;
                    end else if (cnt_inc >= CNT_W'(WRITE_CYC)) begin
                        // cycle is over by its limit
                        mem_ctl_o <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
                        prog_done_o <= 1'b1;
                        busy_o <= 1'b0;
                        req_ready_o <= 1'b1;
                        state <= ST_IDLE;
                    end else begin
                        cnt <= cnt_inc;
                    end
                end
                default: begin
                    state <= ST_INHIBIT;
                    cnt <= '0;
                end
            endcase
        end
    end
endmodule

// [tb/pew_host_properties.sv]
// pin and request-port checks for the eeprom host controller
// bound into pew_host; sees only its ports, one clock domain
`timescale 1ns/10ps
module pew_host_properties
    import pew_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // request side and supply sense
    input wire pew_pkg::pew_req_t req_i,
    input wire logic req_valid_i,
    input wire logic req_ready_o,
    input wire logic [pew_pkg::DATA_W-1:0] rd_data_o,
    input wire logic rd_valid_o,
    input wire logic prog_done_o,
    input wire logic busy_o,
    input wire logic power_good_i,
    // device pins
    input wire logic [pew_pkg::ADDR_W-1:0] mem_addr_o,
    input wire pew_pkg::pew_ctl_t mem_ctl_o,
    input wire logic [pew_pkg::DATA_W-1:0] mem_data_i,
    input wire logic [pew_pkg::DATA_W-1:0] mem_data_o,
    input wire logic mem_data_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic [CNT_W-1:0] since_rst;
    always_ff @(posedge clk_i) begin
        if (!rstn_i)
            since_rst <= '0;
        else if (ce_i && since_rst < CNT_W'(INHIBIT_CYC))
            since_rst <= since_rst + 1'b1;
    end
    sequence read_take;
        ce_i && req_valid_i && req_ready_o && !busy_o && !req_i.write;
    endsequence
    sequence strobe_3;
        !mem_ctl_o.we_n [*3] ##1 mem_ctl_o.we_n;
    endsequence
    a_no_bus_fight: assert property (mem_data_oe_o |-> mem_ctl_o.oe_n)
        else $error("host drives data while output enable is low");
    a_write_oe_high: assert property (!mem_ctl_o.we_n |-> !mem_ctl_o.cs_n && mem_ctl_o.oe_n)
        else $error("strobe low without select or with output enable low");
    a_strobe_width: assert property ($fell(mem_ctl_o.we_n) |-> strobe_3)
        else $error("write strobe not three cycles long");
    a_addr_hold: assert property (!mem_ctl_o.we_n |-> $stable(mem_addr_o))
        else $error("address moves while strobe is low");
    a_data_hold: assert property (!mem_ctl_o.we_n |-> mem_data_oe_o && $stable(mem_data_o))
        else $error("write data not driven steady under the strobe");
    a_inhibit_write: assert property (since_rst < CNT_W'(INHIBIT_CYC) |-> mem_ctl_o.we_n)
        else $error("write strobe inside power-up inhibit");
    a_read_pins: assert property (read_take |=> !mem_ctl_o.cs_n && !mem_ctl_o.oe_n)
        else $error("read not driving select and output enable");
    a_read_answer: assert property (read_take |-> ##[1:10] rd_valid_o)
        else $error("read data valid missing");
    a_done_pulse: assert property (prog_done_o |=> !prog_done_o)
        else $error("program done longer than one cycle");
endmodule
bind pew_host pew_host_properties pew_host_properties_i (.*);

// [tb/pew_eeprom_model.sv]
// behavioural 8k x 8 eeprom with page buffer and completion polling
// pins driven by pew_host; program time shortened by parameter
`timescale 1ns/10ps
module pew_eeprom_model
    import pew_pkg::*;
#(
    parameter int PROG_NS = 10000000
)
(
    // device pins
    input wire logic [pew_pkg::ADDR_W-1:0] addr_i,
    input wire pew_pkg::pew_ctl_t ctl_i,
    input wire logic [pew_pkg::DATA_W-1:0] din_i,
    input wire logic pg_i,
    output logic [pew_pkg::DATA_W-1:0] dout_o
);
    logic [7:0] mem [0:8191];
    logic [7:0] pbuf [0:31];
    logic [31:0] loaded = '0;
    logic [12:0] la = '0;
    logic [7:0] page = '0;
    logic busy = 1'b0;
    logic wr_open = 1'b0;
    logic [7:0] q = '0;
    time last_rise = 0;
    time t_fall = 0;
    time pg_t = 0;
    wire drv = !ctl_i.cs_n && !ctl_i.oe_n && ctl_i.we_n;
    // one byte per address, inverted msb at the last loaded address while busy
    wire [7:0] val = (busy && addr_i == la) ? {~pbuf[la[4:0]][7], addr_i[6:0]} : mem[addr_i];
    initial begin
        for (int i = 0; i < 8192; i++)
            mem[i] = 8'hff;
    end
    always @(posedge pg_i) pg_t = $time;
    // drive only when read; released bus toggles
    always @(drv or val) q = drv ? val : ~q;
    assign dout_o = q;
    always @(negedge ctl_i.we_n or negedge ctl_i.cs_n) begin
        if (!ctl_i.we_n && !ctl_i.cs_n && ctl_i.oe_n && !busy && pg_i && $time - pg_t >= 5000000) begin
            wr_open = 1'b1;
            la = addr_i;
            t_fall = $time;
        end
    end
    always @(posedge ctl_i.we_n or posedge ctl_i.cs_n) begin
        if (wr_open && $time - t_fall >= 20) begin
            if (loaded == 0)
                page = la[12:5];
            pbuf[la[4:0]] = din_i;
            loaded[la[4:0]] = 1'b1;
            last_rise = $time;
        end
        wr_open = 1'b0;
    end
    // commit loaded bytes after 100 us quiet
    always begin
        wait (loaded != 0);
        while ($time - last_rise < 100000)
            #(100000 - ($time - last_rise));
        busy = 1'b1;
        #(PROG_NS);
        for (int i = 0; i < 32; i++) begin
            if (loaded[i])
                mem[{page, i[4:0]}] = pbuf[i];
        end
        loaded = '0;
        busy = 1'b0;
    end
endmodule

// [tb/testbench.sv]
// self-checking bench: pew_host against the eeprom model
// needs pew_pkg, pew_host and the model; checker comes by bind
`timescale 1ns/10ps
module testbench;
    import pew_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic ce_i = 1'b1;
    logic power_good_i = 1'b0;
    logic req_valid_i = 1'b0;
    pew_req_t req_i = '0;
    logic req_ready_o, rd_valid_o, prog_done_o, busy_o, mem_data_oe_o;
    logic [DATA_W-1:0] rd_data_o, mem_data_i, mem_data_o, dev_q, v;
    logic [ADDR_W-1:0] mem_addr_o;
    pew_ctl_t mem_ctl_o;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    localparam int W_READY = 0;
    localparam int W_RDVAL = 1;
    localparam int W_DONE = 2;
    always #25 clk_i = ~clk_i;
    assign mem_data_i = mem_data_oe_o ? mem_data_o : dev_q;
    pew_host pew_host_i (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .req_i(req_i),
        .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o),
        .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o),
        .prog_done_o(prog_done_o),
        .busy_o(busy_o),
        .power_good_i(power_good_i),
        .mem_addr_o(mem_addr_o),
        .mem_ctl_o(mem_ctl_o),
        .mem_data_i(mem_data_i),
        .mem_data_o(mem_data_o),
        .mem_data_oe_o(mem_data_oe_o)
    );
    pew_eeprom_model #(.PROG_NS(50000)) pew_eeprom_model_i (.addr_i(mem_addr_o),
        .ctl_i(mem_ctl_o), .din_i(mem_data_o), .pg_i(power_good_i), .dout_o(dev_q));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // picks the design output that a wait watches
    function automatic logic pick(input int which);
        case (which)
            W_READY: return req_ready_o;
            W_RDVAL: return rd_valid_o;
            default: return prog_done_o;
        endcase
    endfunction
    task automatic wait_for(input int which, input int lim);
        int n;
        n = 0;
        while (pick(which) !== 1'b1 && n < lim) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (pick(which) !== 1'b1) begin
            n_errors++;
            $display("wait limit hit at %0t ns", $time);
        end
    endtask
    task automatic do_req(input logic [12:0] a, input logic [7:0] d, input logic w, input logic l);
        @(posedge clk_i);
        #1;
        req_i = '{a, d, w, l};
        req_valid_i = 1'b1;
        wait_for(W_READY, 1000);
        @(posedge clk_i);
        #1;
        req_valid_i = 1'b0;
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic l);
        do_req(a, d, 1'b1, l);
        if (l)
            wait_for(W_DONE, 20000);
    endtask
    task automatic rd(input logic [12:0] a, output logic [7:0] d);
        do_req(a, 8'h00, 1'b0, 1'b0);
        wait_for(W_RDVAL, 50);
        d = rd_data_o;
    endtask
    task automatic test_inhibit();
        int t0;
        t0 = cycles;
        repeat (100) @(posedge clk_i);
        #1;
        check(8'(req_ready_o), 8'h00);
        check(8'(busy_o), 8'h01);
        wait_for(W_READY, 420000);
        check(8'(cycles - t0 >= INHIBIT_CYC), 8'h01);
        $display("test inhibit done");
    endtask
    task automatic test_bytes();
        wr(13'h1fff, 8'h5a, 1'b1);
        wr(13'h0000, 8'h3c, 1'b1);
        rd(13'h1fff, v);
        check(v, 8'h5a);
        rd(13'h0000, v);
        check(v, 8'h3c);
        $display("test bytes done");
    endtask
    task automatic test_freeze();
        @(posedge clk_i);
        #1;
        ce_i = 1'b0;
        req_i = '{13'h1fff, 8'h00, 1'b0, 1'b0};
        req_valid_i = 1'b1;
        repeat (20) @(posedge clk_i);
        #1;
        check(8'(mem_ctl_o), 8'h07);
        check(8'(rd_valid_o), 8'h00);
        ce_i = 1'b1;
        @(posedge clk_i);
        #1;
        req_valid_i = 1'b0;
        wait_for(W_RDVAL, 50);
        check(rd_data_o, 8'h5a);
        $display("test freeze done");
    endtask
    task automatic test_page();
        wr(13'h0045, 8'h11, 1'b0);
        wr(13'h0041, 8'h22, 1'b0);
        wr(13'h005f, 8'h33, 1'b1);
        rd(13'h0045, v);
        check(v, 8'h11);
        rd(13'h0041, v);
        check(v, 8'h22);
        rd(13'h005f, v);
        check(v, 8'h33);
        rd(13'h0042, v);
        check(v, 8'hff);
        wr(13'h0045, 8'h44, 1'b1);
        rd(13'h0045, v);
        check(v, 8'h44);
        rd(13'h0041, v);
        check(v, 8'h22);
        rd(13'h1fff, v);
        check(v, 8'h5a);
        wr(13'h0100, 8'h66, 1'b0);
        wait_for(W_DONE, 20000);
        rd(13'h0100, v);
        check(v, 8'h66);
        $display("test page done");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 460000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (16) @(posedge clk_i);
        #1;
        rstn_i = 1'b1;
        power_good_i = 1'b1;
        test_inhibit();
        test_bytes();
        test_freeze();
        test_page();
        tally_and_finish();
    end
endmodule
